// ---- src/ksd_decoder.sv ----
/*
  Kernel segment decoder with a small translation buffer and an Avalon-MM register slave.
  Assumes one request per cycle from address generation; results appear one cycle later.
*/
`timescale 1ns/1ps
module ksd_decoder #(
  parameter int TLB_ENTRIES = 32
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [5:0] avs_address, // Register byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer ready
  input wire logic req_valid, // Address to decode
  input wire logic [63:0] req_vaddr, // Virtual address
  output logic dec_valid, // Result valid pulse
  output ksd_pkg::ksd_seg_t dec_segment, // Selected segment
  output logic dec_kernel, // Kernel mode held
  output logic dec_mapped, // Went through lookup
  output logic dec_cached, // Cacheable access
  output logic [2:0] dec_cache_attr, // Cache attribute used
  output logic [7:0] dec_lookup_address_space_identifier, // Identifier appended to lookup
  output logic [27:0] dec_lookup_vpn, // Virtual page looked up
  output logic [31:0] dec_paddr, // Physical address
  output logic dec_addr_error, // Address error
  output logic dec_tlb_miss, // Mapped access missed
  output logic dec_xrefill // Miss goes to extended refill
);
  localparam int IDX_W = $clog2(TLB_ENTRIES);

  generate
    if (TLB_ENTRIES < 2 || TLB_ENTRIES > 32) begin : g_bad_entries
      $error("TLB_ENTRIES must be between 2 and 32");
    end
  endgenerate

  logic [7:0] ctrl_reg;
  logic [ksd_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier_reg;
  logic [IDX_W-1:0] tlb_index_reg;
  logic [ksd_pkg::VPN_W-1:0] tlb_vpn_reg;
  logic [10:0] tlb_tag_reg;
  logic [ksd_pkg::VPN_W-1:0] tlb_vpn_mem [TLB_ENTRIES];
  logic [ksd_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0] tlb_address_space_identifier_mem [TLB_ENTRIES];
  logic [1:0] tlb_region_mem [TLB_ENTRIES];
  logic [TLB_ENTRIES-1:0] tlb_global_reg;
  logic [TLB_ENTRIES-1:0] tlb_valid_reg;
  logic [ksd_pkg::PFN_W-1:0] tlb_pfn_mem [TLB_ENTRIES];
  logic [ksd_pkg::ATTR_W-1:0] tlb_attr_mem [TLB_ENTRIES];
  logic answer_reg;
  logic wr_take;

  logic [1:0] priv;
  logic exception_level_flag;
  logic error_level_flag;
  logic kx;
  logic [2:0] k0_attr;
  logic kernel;

  assign priv = ctrl_reg[ksd_pkg::CTRL_PRIV_LSB +: 2];
  assign exception_level_flag = ctrl_reg[ksd_pkg::CTRL_EXL_BIT];
  assign error_level_flag = ctrl_reg[ksd_pkg::CTRL_ERL_BIT];
  assign kx = ctrl_reg[ksd_pkg::CTRL_KX_BIT];
  assign k0_attr = ctrl_reg[ksd_pkg::CTRL_K0_LSB +: 3];
  assign kernel = (priv == ksd_pkg::PRIV_KERNEL) || exception_level_flag || error_level_flag;

  // Segment classification
  ksd_pkg::ksd_seg_t seg_next;
  logic mapped_next;
  logic cached_next;
  logic [2:0] attr_next;
  logic err_next;
  logic [1:0] region_next;
  logic [ksd_pkg::VPN_W-1:0] vpn_next;
  logic [31:0] direct_pa;
  logic compat;

  assign compat = (req_vaddr[63:62] == ksd_pkg::REGION_KERNEL) && (&req_vaddr[61:31]);

  always_comb begin
    seg_next = ksd_pkg::KSD_SEG_NONE;
    mapped_next = 1'b0;
    cached_next = 1'b0;
    attr_next = ksd_pkg::ATTR_UNCACHED;
    err_next = 1'b0;
    region_next = ksd_pkg::REGION_KERNEL;
    direct_pa = req_vaddr[31:0];
    vpn_next = {8'h00, req_vaddr[31:ksd_pkg::PAGE_W]};
    if (!kernel) begin
      seg_next = ksd_pkg::KSD_SEG_NONE;
    end else if (!kx) begin
      if (!req_vaddr[31]) begin
        seg_next = ksd_pkg::KSD_SEG_USER;
        region_next = ksd_pkg::REGION_USER;
        mapped_next = !error_level_flag;
        direct_pa = req_vaddr[31:0];
      end else if (req_vaddr[31:29] == ksd_pkg::TOP_SEG0) begin
        seg_next = ksd_pkg::KSD_SEG_ZERO;
        direct_pa = req_vaddr[31:0] - ksd_pkg::SEG0_BASE;
        attr_next = k0_attr;
        cached_next = (k0_attr != ksd_pkg::ATTR_UNCACHED);
      end else if (req_vaddr[31:29] == ksd_pkg::TOP_SEG1) begin
        seg_next = ksd_pkg::KSD_SEG_ONE;
        direct_pa = req_vaddr[31:0] - ksd_pkg::SEG1_BASE;
        cached_next = 1'b0;
      end else if (req_vaddr[31:29] == ksd_pkg::TOP_SSEG) begin
        seg_next = ksd_pkg::KSD_SEG_SUPER;
        region_next = ksd_pkg::REGION_SUPER;
        mapped_next = 1'b1;
      end else begin
        seg_next = ksd_pkg::KSD_SEG_THREE;
        mapped_next = 1'b1;
      end
    end else begin
      vpn_next = req_vaddr[ksd_pkg::XVPN_TOP:ksd_pkg::PAGE_W];
      region_next = req_vaddr[63:62];
      if (req_vaddr[63:62] == ksd_pkg::REGION_USER) begin
        seg_next = ksd_pkg::KSD_SEG_XUSER;
        if (error_level_flag) begin
          // Error level leaves only the low 2 GB reachable
          err_next = |req_vaddr[62:31];
        end else begin
          mapped_next = 1'b1;
          err_next = |req_vaddr[61:40];
        end
      end else if (req_vaddr[63:62] == ksd_pkg::REGION_SUPER) begin
        seg_next = ksd_pkg::KSD_SEG_XSUPER;
        mapped_next = 1'b1;
        err_next = |req_vaddr[61:40];
      end else if (req_vaddr[63:62] == ksd_pkg::REGION_PHYS) begin
        seg_next = ksd_pkg::KSD_SEG_XPHYS;
        attr_next = req_vaddr[61:59];
        cached_next = (req_vaddr[61:59] != ksd_pkg::ATTR_UNCACHED);
        err_next = |req_vaddr[58:32];
        direct_pa = req_vaddr[31:0];
      end else if (compat) begin
        vpn_next = {8'h00, req_vaddr[31:ksd_pkg::PAGE_W]};
        if (req_vaddr[31:29] == ksd_pkg::TOP_SEG0) begin
          seg_next = ksd_pkg::KSD_SEG_CZERO;
          direct_pa = req_vaddr[31:0] - ksd_pkg::SEG0_BASE;
          attr_next = k0_attr;
          cached_next = (k0_attr != ksd_pkg::ATTR_UNCACHED);
        end else if (req_vaddr[31:29] == ksd_pkg::TOP_SEG1) begin
          seg_next = ksd_pkg::KSD_SEG_CONE;
          direct_pa = req_vaddr[31:0] - ksd_pkg::SEG1_BASE;
        end else if (req_vaddr[31:29] == ksd_pkg::TOP_SSEG) begin
          seg_next = ksd_pkg::KSD_SEG_CSUPER;
          region_next = ksd_pkg::REGION_SUPER;
          mapped_next = 1'b1;
        end else begin
          seg_next = ksd_pkg::KSD_SEG_CTHREE;
          mapped_next = 1'b1;
        end
      end else begin
        seg_next = ksd_pkg::KSD_SEG_XKERNEL;
        mapped_next = 1'b1;
        // Top 2 GB below the 1 TB line belong to no segment
        err_next = (|req_vaddr[61:40]) || (&req_vaddr[39:ksd_pkg::XKSEG_LIMIT_HI]);
      end
    end
  end

  // Fully associative lookup
  logic hit;
  logic [ksd_pkg::PFN_W-1:0] hit_pfn;
  logic [ksd_pkg::ATTR_W-1:0] hit_attr;

  always_comb begin
    hit = 1'b0;
    hit_pfn = '0;
    hit_attr = ksd_pkg::ATTR_UNCACHED;
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      if (tlb_valid_reg[i] && (tlb_vpn_mem[i] == vpn_next) && (tlb_region_mem[i] == region_next) &&
          (tlb_global_reg[i] || (tlb_address_space_identifier_mem[i] == address_space_identifier_reg)) && !hit) begin
        hit = 1'b1;
        hit_pfn = tlb_pfn_mem[i];
        hit_attr = tlb_attr_mem[i];
      end
    end
  end

  // Decode result registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_segment <= ksd_pkg::KSD_SEG_NONE;
      dec_kernel <= 1'b0;
      dec_mapped <= 1'b0;
      dec_cached <= 1'b0;
      dec_cache_attr <= ksd_pkg::ATTR_UNCACHED;
      dec_lookup_address_space_identifier <= '0;
      dec_lookup_vpn <= '0;
      dec_paddr <= '0;
      dec_addr_error <= 1'b0;
      dec_tlb_miss <= 1'b0;
      dec_xrefill <= 1'b0;
    end else begin
      dec_valid <= req_valid;
      if (req_valid) begin
        dec_segment <= seg_next;
        dec_kernel <= kernel;
        dec_mapped <= mapped_next;
        dec_lookup_address_space_identifier <= address_space_identifier_reg;
        dec_lookup_vpn <= vpn_next;
        dec_addr_error <= err_next;
        dec_tlb_miss <= mapped_next && !err_next && !hit;
        dec_xrefill <= kx;
        if (mapped_next) begin
          dec_paddr <= {hit_pfn, req_vaddr[ksd_pkg::PAGE_W-1:0]};
          dec_cache_attr <= hit_attr;
          dec_cached <= hit && (hit_attr != ksd_pkg::ATTR_UNCACHED);
        end else begin
          dec_paddr <= direct_pa;
          dec_cache_attr <= attr_next;
          dec_cached <= cached_next;
        end
      end
    end
  end

  // Bus handshake: one wait cycle, then answer
  assign wr_take = avs_write && answer_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      answer_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      answer_reg <= (avs_read || avs_write) && !answer_reg;
      avs_waitrequest <= !((avs_read || avs_write) && !answer_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !answer_reg) begin
      if (avs_address == ksd_pkg::REG_CTRL) begin
        avs_readdata <= {24'h000000, ctrl_reg};
      end else if (avs_address == ksd_pkg::REG_ADDRESS_SPACE_IDENTIFIER) begin
        avs_readdata <= {24'h000000, address_space_identifier_reg};
      end else if (avs_address == ksd_pkg::REG_TLB_INDEX) begin
        avs_readdata <= 32'(tlb_index_reg);
      end else if (avs_address == ksd_pkg::REG_TLB_VPN) begin
        avs_readdata <= {4'h0, tlb_vpn_reg};
      end else if (avs_address == ksd_pkg::REG_TLB_TAG) begin
        avs_readdata <= {21'h000000, tlb_tag_reg};
      end else if (avs_address == ksd_pkg::REG_LAST_STATUS) begin
        avs_readdata <= {19'h00000, dec_xrefill, dec_tlb_miss, dec_addr_error, dec_cached,
                         dec_mapped, dec_kernel, dec_cache_attr, dec_segment};
      end else if (avs_address == ksd_pkg::REG_LAST_PADDR) begin
        avs_readdata <= dec_paddr;
      end else begin
        // Frame register is write-only; unmapped reads give zero
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Mode and staging registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= ksd_pkg::CTRL_RESET;
      address_space_identifier_reg <= '0;
      tlb_index_reg <= '0;
      tlb_vpn_reg <= '0;
      tlb_tag_reg <= '0;
    end else if (wr_take) begin
      if (avs_address == ksd_pkg::REG_CTRL) begin
        ctrl_reg <= avs_writedata[7:0];
      end else if (avs_address == ksd_pkg::REG_ADDRESS_SPACE_IDENTIFIER) begin
        address_space_identifier_reg <= avs_writedata[ksd_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0];
      end else if (avs_address == ksd_pkg::REG_TLB_INDEX) begin
        tlb_index_reg <= avs_writedata[IDX_W-1:0];
      end else if (avs_address == ksd_pkg::REG_TLB_VPN) begin
        tlb_vpn_reg <= avs_writedata[ksd_pkg::VPN_W-1:0];
      end else if (avs_address == ksd_pkg::REG_TLB_TAG) begin
        tlb_tag_reg <= avs_writedata[10:0];
      end
    end
  end

  // Writing the frame register commits the staged entry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tlb_valid_reg <= '0;
      tlb_global_reg <= '0;
    end else if (wr_take && (avs_address == ksd_pkg::REG_TLB_PFN)) begin
      tlb_valid_reg[tlb_index_reg] <= avs_writedata[ksd_pkg::PFN_VALID_BIT];
      tlb_global_reg[tlb_index_reg] <= tlb_tag_reg[ksd_pkg::TAG_GLOBAL_BIT];
    end
  end

  // Entry contents need no reset; the valid bits guard them
  always_ff @(posedge clk_sys) begin
    if (wr_take && (avs_address == ksd_pkg::REG_TLB_PFN)) begin
      tlb_vpn_mem[tlb_index_reg] <= tlb_vpn_reg;
      tlb_address_space_identifier_mem[tlb_index_reg] <= tlb_tag_reg[ksd_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0];
      tlb_region_mem[tlb_index_reg] <= tlb_tag_reg[ksd_pkg::TAG_REGION_LSB +: 2];
      tlb_pfn_mem[tlb_index_reg] <= avs_writedata[ksd_pkg::PFN_W-1:0];
      tlb_attr_mem[tlb_index_reg] <= avs_writedata[ksd_pkg::PFN_ATTR_LSB +: ksd_pkg::ATTR_W];
    end
  end
endmodule

// ---- src/ksd_pkg.sv ----
/*
  Constants, register map and types for the kernel segment decoder.
  Assumes a 64-bit virtual address, 32-bit physical address and an Avalon-MM register port.
*/
package ksd_pkg;
  localparam int VA_W = 64;
  localparam int PA_W = 32;
  localparam int PAGE_W = 12;
  localparam int VPN_W = 28;
  localparam int PFN_W = 20;
  localparam int ADDRESS_SPACE_IDENTIFIER_W = 8;
  localparam int ATTR_W = 3;

  // Register byte addresses
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_ADDRESS_SPACE_IDENTIFIER = 6'h04;
  localparam logic [5:0] REG_TLB_INDEX = 6'h08;
  localparam logic [5:0] REG_TLB_VPN = 6'h0c;
  localparam logic [5:0] REG_TLB_TAG = 6'h10;
  localparam logic [5:0] REG_TLB_PFN = 6'h14;
  localparam logic [5:0] REG_LAST_STATUS = 6'h18;
  localparam logic [5:0] REG_LAST_PADDR = 6'h1c;

  // Control register fields
  localparam int CTRL_PRIV_LSB = 0;
  localparam int CTRL_EXL_BIT = 2;
  localparam int CTRL_ERL_BIT = 3;
  localparam int CTRL_KX_BIT = 4;
  localparam int CTRL_K0_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // Translation buffer tag and frame fields
  localparam int TAG_REGION_LSB = 8;
  localparam int TAG_GLOBAL_BIT = 10;
  localparam int PFN_ATTR_LSB = 20;
  localparam int PFN_VALID_BIT = 23;

  localparam logic [ATTR_W-1:0] ATTR_UNCACHED = 3'h2;
  localparam logic [31:0] SEG0_BASE = 32'h8000_0000;
  localparam logic [31:0] SEG1_BASE = 32'ha000_0000;
  localparam logic [2:0] TOP_SEG0 = 3'h4;
  localparam logic [2:0] TOP_SEG1 = 3'h5;
  localparam logic [2:0] TOP_SSEG = 3'h6;
  localparam logic [1:0] REGION_USER = 2'h0;
  localparam logic [1:0] REGION_SUPER = 2'h1;
  localparam logic [1:0] REGION_PHYS = 2'h2;
  localparam logic [1:0] REGION_KERNEL = 2'h3;
  localparam int XVPN_TOP = 39;
  localparam int XKSEG_LIMIT_HI = 31;

  typedef enum logic [3:0] {
    KSD_SEG_NONE, KSD_SEG_USER, KSD_SEG_ZERO, KSD_SEG_ONE, KSD_SEG_SUPER, KSD_SEG_THREE,
    KSD_SEG_XUSER, KSD_SEG_XSUPER, KSD_SEG_XPHYS, KSD_SEG_XKERNEL,
    KSD_SEG_CZERO, KSD_SEG_CONE, KSD_SEG_CSUPER, KSD_SEG_CTHREE
  } ksd_seg_t;
endpackage

// ---- tb/ksd_agu_model.sv ----
/*
  Address generation model: issues one decode request per call.
  Assumes the caller enters just after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module ksd_agu_model (
  input wire logic clk_sys, // Clock
  output logic req_valid, // Decode request
  output logic [63:0] req_vaddr // Virtual address
);
  initial begin
    req_valid = 1'b0;
    req_vaddr = 64'h0;
  end
  task automatic issue(input logic [63:0] va);
    req_valid <= 1'b1;
    req_vaddr <= va;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // Stale bus shows garbage, so a late sample cannot pass
    req_vaddr <= ~va;
  endtask
endmodule

// ---- tb/ksd_monitor.sv ----
/*
  Checker for the kernel segment decoder ports.
  Assumes a bind from the testbench file; one clock domain.
*/
`timescale 1ns/1ps
module ksd_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic req_valid, // Request
  input wire logic [63:0] req_vaddr, // Address
  input wire logic dec_valid, // Result
  input wire ksd_pkg::ksd_seg_t dec_segment, // Segment
  input wire logic dec_mapped, // Mapped
  input wire logic dec_cached, // Cached
  input wire logic [2:0] dec_cache_attr, // Attribute
  input wire logic [31:0] dec_paddr, // Physical
  input wire logic dec_addr_error, // Error
  input wire logic dec_tlb_miss // Miss
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [63:0] va_q;
  always_ff @(posedge clk_sys) begin
    va_q <= req_vaddr;
  end
  AST_DEC_PULSE: assert property (dec_valid == $past(req_valid)) else $error("decode pulse wrong");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_SEG_ZERO: assert property (dec_valid && dec_segment == ksd_pkg::KSD_SEG_ZERO |->
    va_q[31:29] == 3'h4 && !dec_mapped && dec_paddr == va_q[31:0] - 32'h8000_0000) else $error("seg zero");
  AST_SEG_ONE: assert property (dec_valid && dec_segment == ksd_pkg::KSD_SEG_ONE |->
    va_q[31:29] == 3'h5 && !dec_mapped && dec_paddr == va_q[31:0] - 32'ha000_0000) else $error("seg one");
  AST_ONE_UNCACHED: assert property (dec_valid && dec_segment inside {ksd_pkg::KSD_SEG_ONE,
    ksd_pkg::KSD_SEG_CONE} |-> !dec_cached) else $error("seg one cached");
  AST_CACHED_ATTR: assert property (dec_valid |-> dec_cached == (dec_cache_attr != 3'h2))
    else $error("cached flag mismatch");
  AST_XPHYS: assert property (dec_valid && dec_segment == ksd_pkg::KSD_SEG_XPHYS |->
    !dec_mapped && !dec_tlb_miss && dec_paddr == va_q[31:0]) else $error("phys window");
  AST_XPHYS_ERR: assert property (dec_valid && dec_segment == ksd_pkg::KSD_SEG_XPHYS |->
    dec_addr_error == (va_q[58:32] != 27'h0)) else $error("phys window error");
  AST_COMPAT: assert property (dec_valid && dec_segment inside {ksd_pkg::KSD_SEG_CZERO,
    ksd_pkg::KSD_SEG_CONE, ksd_pkg::KSD_SEG_CSUPER, ksd_pkg::KSD_SEG_CTHREE} |->
    va_q[63:31] == 33'h1_ffff_ffff) else $error("compat select");
  AST_MAPPED: assert property (dec_valid && dec_segment inside {ksd_pkg::KSD_SEG_SUPER,
    ksd_pkg::KSD_SEG_THREE, ksd_pkg::KSD_SEG_XSUPER, ksd_pkg::KSD_SEG_XKERNEL,
    ksd_pkg::KSD_SEG_CSUPER, ksd_pkg::KSD_SEG_CTHREE} |-> dec_mapped) else $error("not mapped");
  AST_MISS: assert property (dec_tlb_miss |-> dec_mapped && !dec_addr_error)
    else $error("miss unmapped");
  COV_ZERO: cover property (dec_valid && dec_segment == ksd_pkg::KSD_SEG_ZERO);
  COV_PHYS_ERR: cover property (dec_valid && dec_addr_error);
  COV_HIT: cover property (dec_valid && dec_mapped && !dec_tlb_miss);
endmodule

// ---- tb/testbench.sv ----
/*
  Directed testbench for the kernel segment decoder.
  Assumes the design package, model and checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, req_valid;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, dec_paddr, q;
  logic [63:0] req_vaddr;
  logic dec_valid, dec_kernel, dec_mapped, dec_cached, dec_addr_error, dec_tlb_miss, dec_xrefill;
  logic [2:0] dec_cache_attr;
  logic [7:0] dec_lookup_address_space_identifier;
  logic [27:0] dec_lookup_vpn;
  ksd_pkg::ksd_seg_t dec_segment;
  int errors = 0, num_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  ksd_agu_model i_agu (.clk_sys, .req_valid, .req_vaddr);
  ksd_decoder i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .req_valid, .req_vaddr, .dec_valid, .dec_segment, .dec_kernel, .dec_mapped, .dec_cached,
    .dec_cache_attr, .dec_lookup_address_space_identifier, .dec_lookup_vpn, .dec_paddr, .dec_addr_error, .dec_tlb_miss, .dec_xrefill);
  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let the release reach the slave before the next request
    @(posedge clk_sys);
  endtask
  task automatic probe(input logic [63:0] va, input ksd_pkg::ksd_seg_t s, input logic m, input logic [31:0] pa);
    i_agu.issue(va);
    #1;
    cmp(dec_valid, 1'b1);
    cmp(dec_segment, s);
    cmp(dec_mapped, m);
    if (!m) cmp(dec_paddr, pa);
    @(posedge clk_sys);
  endtask
  task automatic t_regs();
    rw(1'b0, ksd_pkg::REG_CTRL, 32'h0);
    cmp(q, 32'h0);
    rw(1'b0, 6'h20, 32'h0); // Unmapped reads zero
    cmp(q, 32'h0);
    rw(1'b1, ksd_pkg::REG_ADDRESS_SPACE_IDENTIFIER, 32'h5a);
    rw(1'b0, ksd_pkg::REG_ADDRESS_SPACE_IDENTIFIER, 32'h0);
    cmp(q, 32'h5a);
  endtask
  task automatic t_kernel();
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h01);
    // Outside kernel mode the address passes through untranslated
    probe(64'hffff_ffff_8000_0010, ksd_pkg::KSD_SEG_NONE, 1'b0, 32'h8000_0010);
    cmp(dec_kernel, 1'b0);
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h05);
    probe(64'hffff_ffff_8000_0010, ksd_pkg::KSD_SEG_ZERO, 1'b0, 32'h10);
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h0a);
    probe(64'hffff_ffff_8000_0010, ksd_pkg::KSD_SEG_ZERO, 1'b0, 32'h10);
    cmp(dec_kernel, 1'b1);
  endtask
  task automatic t_seg32();
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h60);
    probe(64'h0000_0000_7fff_f000, ksd_pkg::KSD_SEG_USER, 1'b1, 32'h0);
    cmp({dec_tlb_miss, dec_xrefill}, 2'h2);
    probe(64'hffff_ffff_8000_1234, ksd_pkg::KSD_SEG_ZERO, 1'b0, 32'h1234);
    cmp({dec_cached, dec_cache_attr}, 4'hb);
    probe(64'hffff_ffff_bfff_fffc, ksd_pkg::KSD_SEG_ONE, 1'b0, 32'h1fff_fffc);
    cmp(dec_cached, 1'b0);
    probe(64'hffff_ffff_c000_0000, ksd_pkg::KSD_SEG_SUPER, 1'b1, 32'h0);
    probe(64'hffff_ffff_ffff_f000, ksd_pkg::KSD_SEG_THREE, 1'b1, 32'h0);
  endtask
  task automatic t_seg64();
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h50);
    probe(64'h0000_00ff_ffff_f000, ksd_pkg::KSD_SEG_XUSER, 1'b1, 32'h0);
    cmp({dec_tlb_miss, dec_xrefill}, 2'h3);
    probe(64'h4000_00ff_ffff_f000, ksd_pkg::KSD_SEG_XSUPER, 1'b1, 32'h0);
    probe(64'h9000_0000_1234_5678, ksd_pkg::KSD_SEG_XPHYS, 1'b0, 32'h1234_5678);
    cmp(dec_addr_error, 1'b0);
    probe(64'h8000_0001_0000_0000, ksd_pkg::KSD_SEG_XPHYS, 1'b0, 32'h0);
    cmp(dec_addr_error, 1'b1);
    probe(64'hc000_00ff_7fff_f000, ksd_pkg::KSD_SEG_XKERNEL, 1'b1, 32'h0);
    probe(64'hffff_ffff_8000_0040, ksd_pkg::KSD_SEG_CZERO, 1'b0, 32'h40);
    cmp({dec_cached, dec_cache_attr}, 4'h2);
    probe(64'hffff_ffff_a000_0040, ksd_pkg::KSD_SEG_CONE, 1'b0, 32'h40);
    probe(64'hffff_ffff_c000_0000, ksd_pkg::KSD_SEG_CSUPER, 1'b1, 32'h0);
    probe(64'hffff_ffff_e000_0000, ksd_pkg::KSD_SEG_CTHREE, 1'b1, 32'h0);
  endtask
  task automatic t_erl();
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h6b);
    probe(64'h0000_0000_1234_5678, ksd_pkg::KSD_SEG_USER, 1'b0, 32'h1234_5678);
    cmp(dec_cached, 1'b0);
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h7b);
    probe(64'h0000_0000_7fff_fff0, ksd_pkg::KSD_SEG_XUSER, 1'b0, 32'h7fff_fff0);
  endtask
  task automatic t_tlb();
    rw(1'b1, ksd_pkg::REG_CTRL, 32'h0);
    rw(1'b1, ksd_pkg::REG_TLB_INDEX, 32'h1f);
    rw(1'b1, ksd_pkg::REG_TLB_VPN, 32'h00c_0005);
    rw(1'b1, ksd_pkg::REG_TLB_TAG, 32'h15a);
    rw(1'b1, ksd_pkg::REG_TLB_PFN, 32'hb1_2345);
    probe(64'hffff_ffff_c000_5abc, ksd_pkg::KSD_SEG_SUPER, 1'b1, 32'h0);
    cmp({dec_tlb_miss, dec_lookup_address_space_identifier, dec_paddr}, 41'h05a_1234_5abc);
    cmp(dec_lookup_vpn, 28'h00c_0005);
    rw(1'b0, ksd_pkg::REG_LAST_PADDR, 32'h0);
    cmp(q, 32'h1234_5abc);
    rw(1'b1, ksd_pkg::REG_ADDRESS_SPACE_IDENTIFIER, 32'h5b);
    probe(64'hffff_ffff_c000_5abc, ksd_pkg::KSD_SEG_SUPER, 1'b1, 32'h0);
    cmp({dec_tlb_miss, dec_lookup_address_space_identifier}, 9'h15b);
    // Status: miss, mapped, kernel, uncached attribute, supervisor segment
    rw(1'b0, ksd_pkg::REG_LAST_STATUS, 32'h0);
    cmp(q, 32'h0000_09a4);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp({avs_waitrequest, dec_valid}, 2'h2);
    t_regs();
    t_kernel();
    t_seg32();
    t_seg64();
    t_erl();
    t_tlb();
    summarize();
  end
endmodule
bind ksd_decoder ksd_monitor i_mon (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest, .req_valid,
  .req_vaddr, .dec_valid, .dec_segment, .dec_mapped, .dec_cached, .dec_cache_attr, .dec_paddr,
  .dec_addr_error, .dec_tlb_miss);
